// file: core/piss_pkg.sv
// Purpose: constants and carrier types for the peripheral input source select block
// Assumes: 16-bit source-select registers reached over 32-bit APB
// Notes: offsets are register indices; byte address is four times the index
package piss_pkg;
    // ========================================
    // register map
    localparam logic [7:0] PISS_IDX_PWM_SEL = 8'h18;
    localparam logic [7:0] PISS_IDX_DAC_SEL = 8'h19;
    localparam logic [9:0] PISS_ADDR_PWM_SEL = {PISS_IDX_PWM_SEL, 2'b00};
    localparam logic [9:0] PISS_ADDR_DAC_SEL = {PISS_IDX_DAC_SEL, 2'b00};
    localparam logic [15:0] PISS_RST_PWM_SEL = 16'h0000;
    localparam logic [15:0] PISS_RST_DAC_SEL = 16'h0000;
    // writable bits; reserved bits store and read as zero
    localparam logic [15:0] PISS_MASK_PWM_SEL = 16'h29FF;
    localparam logic [15:0] PISS_MASK_DAC_SEL = 16'h0077;
    // ========================================
    // field positions
    localparam int PISS_POS_FAULT_TWO = 13;
    localparam int PISS_POS_FAULT_ONE = 11;
    localparam int PISS_POS_PAIR_TWO = 6;
    localparam int PISS_POS_PAIR_ONE = 3;
    localparam int PISS_POS_PAIR_ZERO = 0;
    localparam int PISS_POS_DAC1 = 4;
    localparam int PISS_POS_DAC0 = 0;
    // ========================================
    // source codes
    localparam logic [2:0] PISS_PAIR_PIN = 3'h0;
    localparam logic [2:0] PISS_PAIR_TIMER = 3'h1;
    localparam logic [2:0] PISS_PAIR_ADC = 3'h2;
    localparam logic [2:0] PISS_PAIR_CMPA = 3'h3;
    localparam logic [2:0] PISS_PAIR_CMPB = 3'h4;
    localparam logic [2:0] PISS_DSYNC_PIT = 3'h0;
    localparam logic [2:0] PISS_DSYNC_PWM = 3'h3;
    localparam logic [2:0] PISS_DSYNC_TA0 = 3'h4;
    localparam logic [2:0] PISS_DSYNC_TA1 = 3'h5;
    // ========================================
    // carriers
    typedef struct packed {
        logic paddr_ok;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } piss_apb_rsp_t;
    typedef struct packed {
        logic force_en;
        logic even_val;
        logic odd_val;
    } piss_pair_force_t;
endpackage : piss_pkg

// file: core/piss_source_select.sv
// Purpose: selects sources for PWM fault and pair inputs and DAC sync inputs
// Assumes: peripheral sources share core_clk; pins and pin enables are asynchronous
// Notes: one-cycle APB answer, outputs registered
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - fault-two bit 13: 0 takes pin, 1 takes comparator B
// - fault-one bit 11: 0 takes pin, 1 takes comparator A
// - pair-two field bits 8:6: timer A3, ADC two, comp A, comp B; 000 reserved
// - ADC two above high limit two forces PWM4 low, PWM5 high
// - ADC two below low limit two forces PWM4 high, PWM5 low
// - pair-one field bits 5:3: pin, timer A2, ADC one, comp A, comp B
// - ADC one beyond limits forces PWM2/PWM3 opposite levels
// - pair-zero field bits 2:0: pin, timer A0, ADC zero, comp A, comp B
// - ADC zero beyond limits forces PWM0/PWM1 opposite levels
// - DAC1 sync field bits 6:4: interval timer, PWM sync, timer A0, A1
// - DAC0 sync field bits 2:0 uses the same coding
// - pin with peripheral-enable low is not a peripheral source
module piss_source_select #(
    parameter int ADC_W = 12
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external pins and their peripheral enables (asynchronous)
    input wire logic fault_two_pin,
    input wire logic fault_one_pin,
    input wire logic [1:0] pair_pin,
    input wire logic [3:0] pin_peripheral_enable,
    // on-chip sources
    input wire logic comparator_a_out,
    input wire logic comparator_b_out,
    input wire logic timer_a_ch0,
    input wire logic timer_a_ch1,
    input wire logic timer_a_ch2,
    input wire logic timer_a_ch3,
    input wire logic interval_timer_zero_out,
    input wire logic pwm_reload_sync,
    input wire logic [ADC_W-1:0] adc_result_zero,
    input wire logic [ADC_W-1:0] adc_result_one,
    input wire logic [ADC_W-1:0] adc_result_two,
    input wire logic [ADC_W-1:0] high_limit_zero,
    input wire logic [ADC_W-1:0] high_limit_one,
    input wire logic [ADC_W-1:0] high_limit_two,
    input wire logic [ADC_W-1:0] low_limit_zero,
    input wire logic [ADC_W-1:0] low_limit_one,
    input wire logic [ADC_W-1:0] low_limit_two,
    // to peripherals
    output logic pwm_fault_two_in,
    output logic pwm_fault_one_in,
    output logic [2:0] pwm_pair_src,
    output logic [2:0] pwm_pair_force,
    output logic [5:0] pwm_force_val,
    output logic dac1_sync_in,
    output logic dac0_sync_in
);
    import piss_pkg::*;

    // ========================================
    // pin synchronisers; [0] feeds only [1]
    logic [3:0] pin_raw;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pen_meta;
    logic [3:0] pen_sync;
    assign pin_raw = {fault_two_pin, fault_one_pin, pair_pin};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            pen_meta <= 4'h0;
            pen_sync <= 4'h0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pen_meta <= pin_peripheral_enable;
            pen_sync <= pen_meta;
        end
    end

    // gpio-owned pins read as zero
    logic [3:0] pin_ok;
    assign pin_ok = pin_sync & pen_sync;

    // ========================================
    // registers and apb
    logic [15:0] pwm_sel;
    logic [15:0] dac_sel;
    logic [15:0] next_pwm_sel;
    logic [15:0] next_dac_sel;
    piss_apb_rsp_t rsp;
    piss_apb_rsp_t next_rsp;
    logic setup;
    logic hit_pwm;
    logic hit_dac;
    logic [15:0] wdat;

    always_comb begin
        setup = psel && !penable;
        hit_pwm = paddr[9:0] == PISS_ADDR_PWM_SEL && paddr[31:10] == 22'h0;
        hit_dac = paddr[9:0] == PISS_ADDR_DAC_SEL && paddr[31:10] == 22'h0;
        wdat = pwdata[15:0];
        next_pwm_sel = pwm_sel;
        next_dac_sel = dac_sel;
        next_rsp = '0;
        // the access completes in the cycle after setup; writes land at that edge
        if (psel && penable && rsp.pready) begin
            if (pwrite && rsp.paddr_ok && pstrb[1:0] == 2'b11) begin
                if (hit_pwm) begin
                    next_pwm_sel = wdat & PISS_MASK_PWM_SEL;
                end else if (hit_dac) begin
                    next_dac_sel = wdat & PISS_MASK_DAC_SEL;
                end
            end
        end else if (setup) begin
            next_rsp.pready = 1'b1;
            next_rsp.paddr_ok = hit_pwm || hit_dac;
            next_rsp.pslverr = !(hit_pwm || hit_dac);
            if (!pwrite && hit_pwm) begin
                next_rsp.prdata = {16'h0000, pwm_sel};
            end else if (!pwrite && hit_dac) begin
                next_rsp.prdata = {16'h0000, dac_sel};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwm_sel <= PISS_RST_PWM_SEL;
            dac_sel <= PISS_RST_DAC_SEL;
            rsp <= '0;
        end else begin
            pwm_sel <= next_pwm_sel;
            dac_sel <= next_dac_sel;
            rsp <= next_rsp;
        end
    end

    assign prdata = rsp.prdata;
    assign pready = rsp.pready;
    assign pslverr = rsp.pslverr;

    // ========================================
    // source muxing
    logic [2:0] pair_code [3];
    logic [2:0] pair_tmr;
    logic [ADC_W-1:0] adc_res [3];
    logic [ADC_W-1:0] adc_hi [3];
    logic [ADC_W-1:0] adc_lo [3];
    logic [2:0] pair_pin_ok;
    logic [2:0] next_pair_src;
    logic [2:0] next_pair_force;
    logic [5:0] next_force_val;
    logic next_fault_two;
    logic next_fault_one;
    logic next_dac1;
    logic next_dac0;

    assign pair_code[0] = pwm_sel[PISS_POS_PAIR_ZERO +: 3];
    assign pair_code[1] = pwm_sel[PISS_POS_PAIR_ONE +: 3];
    assign pair_code[2] = pwm_sel[PISS_POS_PAIR_TWO +: 3];
    assign pair_tmr = {timer_a_ch3, timer_a_ch2, timer_a_ch0};
    // pair two has no pin source
    assign pair_pin_ok = {1'b0, pin_ok[1:0]};
    assign adc_res = '{adc_result_zero, adc_result_one, adc_result_two};
    assign adc_hi = '{high_limit_zero, high_limit_one, high_limit_two};
    assign adc_lo = '{low_limit_zero, low_limit_one, low_limit_two};

    for (genvar g = 0; g < 3; g++) begin : g_pair
        always_comb begin
            next_pair_src[g] = 1'b0;
            next_pair_force[g] = 1'b0;
            next_force_val[2*g +: 2] = 2'b00;
            case (pair_code[g])
                PISS_PAIR_PIN: next_pair_src[g] = pair_pin_ok[g];
                PISS_PAIR_TIMER: next_pair_src[g] = pair_tmr[g];
                PISS_PAIR_CMPA: next_pair_src[g] = comparator_a_out;
                PISS_PAIR_CMPB: next_pair_src[g] = comparator_b_out;
                PISS_PAIR_ADC: begin
                    if (adc_res[g] > adc_hi[g]) begin
                        next_pair_force[g] = 1'b1;
                        next_force_val[2*g +: 2] = 2'b10;
                    end else if (adc_res[g] < adc_lo[g]) begin
                        next_pair_force[g] = 1'b1;
                        next_force_val[2*g +: 2] = 2'b01;
                    end
                end
                default: next_pair_src[g] = 1'b0;
            endcase
        end
    end

    function automatic logic dsync(input logic [2:0] code, input logic pit, input logic psync,
                                   input logic ta0, input logic ta1);
        case (code)
            PISS_DSYNC_PIT: dsync = pit;
            PISS_DSYNC_PWM: dsync = psync;
            PISS_DSYNC_TA0: dsync = ta0;
            PISS_DSYNC_TA1: dsync = ta1;
            default: dsync = 1'b0;
        endcase
    endfunction : dsync

    always_comb begin
        next_fault_two = pwm_sel[PISS_POS_FAULT_TWO] ? comparator_b_out : pin_ok[3];
        next_fault_one = pwm_sel[PISS_POS_FAULT_ONE] ? comparator_a_out : pin_ok[2];
        next_dac1 = dsync(dac_sel[PISS_POS_DAC1 +: 3], interval_timer_zero_out, pwm_reload_sync,
                          timer_a_ch0, timer_a_ch1);
        next_dac0 = dsync(dac_sel[PISS_POS_DAC0 +: 3], interval_timer_zero_out, pwm_reload_sync,
                          timer_a_ch0, timer_a_ch1);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwm_fault_two_in <= 1'b0;
            pwm_fault_one_in <= 1'b0;
            pwm_pair_src <= 3'h0;
            pwm_pair_force <= 3'h0;
            pwm_force_val <= 6'h00;
            dac1_sync_in <= 1'b0;
            dac0_sync_in <= 1'b0;
        end else begin
            pwm_fault_two_in <= next_fault_two;
            pwm_fault_one_in <= next_fault_one;
            pwm_pair_src <= next_pair_src;
            pwm_pair_force <= next_pair_force;
            pwm_force_val <= next_force_val;
            dac1_sync_in <= next_dac1;
            dac0_sync_in <= next_dac0;
        end
    end

    // ========================================
    // checks
    a_fault_two_cmp: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[13] |=> pwm_fault_two_in == $past(comparator_b_out))
        else $error("fault two not from comparator b");
    a_fault_one_cmp: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[11] |=> pwm_fault_one_in == $past(comparator_a_out))
        else $error("fault one not from comparator a");
    a_pair_two_timer: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[8:6] == 3'h1 |=> pwm_pair_src[2] == $past(timer_a_ch3))
        else $error("pair two not from timer a3");
    a_pair_two_high: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[8:6] == 3'h2 && adc_result_two > high_limit_two
        |=> pwm_pair_force[2] && pwm_force_val[5:4] == 2'b10)
        else $error("pair two high force wrong");
    a_pair_two_low: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[8:6] == 3'h2 && adc_result_two < low_limit_two && adc_result_two <= high_limit_two
        |=> pwm_pair_force[2] && pwm_force_val[5:4] == 2'b01)
        else $error("pair two low force wrong");
    a_pair_one_cmpb: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[5:3] == 3'h4 |=> pwm_pair_src[1] == $past(comparator_b_out))
        else $error("pair one not from comparator b");
    a_pair_one_high: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[5:3] == 3'h2 && adc_result_one > high_limit_one |=> pwm_force_val[3:2] == 2'b10)
        else $error("pair one high force wrong");
    a_pair_zero_cmpa: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[2:0] == 3'h3 |=> pwm_pair_src[0] == $past(comparator_a_out))
        else $error("pair zero not from comparator a");
    a_pair_zero_low: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[2:0] == 3'h2 && adc_result_zero < low_limit_zero && adc_result_zero <= high_limit_zero
        |=> pwm_force_val[1:0] == 2'b01)
        else $error("pair zero low force wrong");
    a_dac1_pwm_sync: assert property (@(posedge core_clk) disable iff (rst)
        dac_sel[6:4] == 3'h3 |=> dac1_sync_in == $past(pwm_reload_sync))
        else $error("dac1 sync not from pwm reload");
    a_dac0_timer_a1: assert property (@(posedge core_clk) disable iff (rst)
        dac_sel[2:0] == 3'h5 |=> dac0_sync_in == $past(timer_a_ch1))
        else $error("dac0 sync not from timer a1");
    a_pin_gated_off: assert property (@(posedge core_clk) disable iff (rst)
        !pen_sync[3] && !pwm_sel[13] |=> !pwm_fault_two_in)
        else $error("disabled pin reached fault two");
    a_reserved_code_zero: assert property (@(posedge core_clk) disable iff (rst)
        dac_sel[2:0] inside {3'h1, 3'h2, 3'h6, 3'h7} |=> !dac0_sync_in)
        else $error("reserved dac0 code not zero");
    a_pair_one_low: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[5:3] == 3'h2 && adc_result_one < low_limit_one && adc_result_one <= high_limit_one
        |=> pwm_pair_force[1] && pwm_force_val[3:2] == 2'b01)
        else $error("pair one low force wrong");
    a_pair_zero_high: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[2:0] == 3'h2 && adc_result_zero > high_limit_zero
        |=> pwm_pair_force[0] && pwm_force_val[1:0] == 2'b10)
        else $error("pair zero high force wrong");
    // pair two has no pin source, so its default code must stay silent
    a_pair_two_reserved: assert property (@(posedge core_clk) disable iff (rst)
        pwm_sel[8:6] == 3'h0 |=> !pwm_pair_src[2] && !pwm_pair_force[2])
        else $error("pair two default code not zero");
    a_fault_one_gated: assert property (@(posedge core_clk) disable iff (rst)
        !pen_sync[2] && !pwm_sel[11] |=> !pwm_fault_one_in)
        else $error("disabled pin reached fault one");
endmodule : piss_source_select
`default_nettype wire

// file: testbench/peripheral_input_source_select_tb_top.sv
// Purpose: self-checking bench for the source select block
// Assumes: one-cycle APB answer, outputs one edge behind inputs, pins two more
// Notes: four source patterns give every source a distinct signature
`timescale 1ns/100ps
`default_nettype none
module peripheral_input_source_select_tb_top;
    import piss_pkg::*;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb, en;
    logic [1:0] pair_pin;
    logic fault_one_pin, fault_two_pin;
    logic [7:0] pat, src;
    logic [5:0] adc_mode, pwm_force_val;
    logic [11:0] hi, lo;
    logic [35:0] adc;
    logic f2, f1, d1, d0;
    logic [2:0] pwm_pair_src, pwm_pair_force;
    logic [15:0] out_vec;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] pats [4] = '{8'hAA, 8'hCC, 8'hF0, 8'hFF};
    assign out_vec = {f2, f1, pwm_pair_src, pwm_pair_force, pwm_force_val, d1, d0};
    piss_periph_model PEER (.core_clk(core_clk), .rst(rst), .pat(pat), .adc_mode(adc_mode),
        .src(src), .hi_lim(hi), .lo_lim(lo), .adc_res(adc));
    piss_source_select #(.ADC_W(12)) DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_two_pin(fault_two_pin),
        .fault_one_pin(fault_one_pin), .pair_pin(pair_pin), .pin_peripheral_enable(en),
        .comparator_a_out(src[0]), .comparator_b_out(src[1]), .timer_a_ch0(src[2]),
        .timer_a_ch1(src[3]), .timer_a_ch2(src[4]), .timer_a_ch3(src[5]),
        .interval_timer_zero_out(src[6]), .pwm_reload_sync(src[7]),
        .adc_result_zero(adc[11:0]), .adc_result_one(adc[23:12]), .adc_result_two(adc[35:24]),
        .high_limit_zero(hi), .high_limit_one(hi), .high_limit_two(hi), .low_limit_zero(lo),
        .low_limit_one(lo), .low_limit_two(lo), .pwm_fault_two_in(f2), .pwm_fault_one_in(f1),
        .pwm_pair_src(pwm_pair_src), .pwm_pair_force(pwm_pair_force),
        .pwm_force_val(pwm_force_val), .dac1_sync_in(d1), .dac0_sync_in(d0));
    // ====
    // utilities
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // entered just after a rising edge; request held until pready is seen
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never drives psel twice in one time step
        @(posedge core_clk);
    endtask : apb
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic x;
        apb(1'b1, a, d, r, x);
        chk("write pslverr", {31'h0, x}, 32'h0);
    endtask : reg_wr
    task automatic reg_rd(input logic [31:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] r;
        logic x;
        apb(1'b0, a, 32'h0, r, x);
        chk("read data", r, e);
        chk("read pslverr", {31'h0, x}, {31'h0, ee});
    endtask : reg_rd
    function automatic logic [15:0] expect_out(input logic [2:0] c, input logic [3:0] e,
                                               input logic [7:0] p);
        logic [2:0] s;
        logic [2:0] tmr;
        logic d;
        tmr = {p[5], p[4], p[2]};
        for (int g = 0; g < 3; g++) begin
            case (c)
                3'h0: s[g] = (g < 2) ? (~p[g] & e[g]) : 1'b0;
                3'h1: s[g] = tmr[g];
                3'h3: s[g] = p[0];
                3'h4: s[g] = p[1];
                default: s[g] = 1'b0;
            endcase
        end
        case (c)
            3'h0: d = p[6];
            3'h3: d = p[7];
            3'h4: d = p[2];
            3'h5: d = p[3];
            default: d = 1'b0;
        endcase
        expect_out = {c[0] ? p[1] : (~p[3] & e[3]), c[1] ? p[0] : (~p[2] & e[2]), s,
                      {3{c == 3'h2}}, (c == 3'h2) ? 6'h2A : 6'h00, d, d};
    endfunction : expect_out
    // ====
    // scenarios
    task automatic t_map();
        reg_rd({22'h0, PISS_ADDR_PWM_SEL}, 32'h0, 1'b0);
        reg_rd({22'h0, PISS_ADDR_DAC_SEL}, 32'h0, 1'b0);
        reg_rd(32'h0000_0068, 32'h0, 1'b1);
        reg_wr({22'h0, PISS_ADDR_PWM_SEL}, 32'h0000_29FF);
        reg_wr({22'h0, PISS_ADDR_DAC_SEL}, 32'h0000_0077);
        // a write without both low byte strobes is dropped
        pstrb <= 4'hC;
        reg_wr({22'h0, PISS_ADDR_PWM_SEL}, 32'h0000_0000);
        pstrb <= 4'hF;
        reg_rd({22'h0, PISS_ADDR_PWM_SEL}, 32'h0000_29FF, 1'b0);
        reg_rd({22'h0, PISS_ADDR_DAC_SEL}, 32'h0000_0077, 1'b0);
    endtask : t_map
    task automatic t_codes();
        logic [2:0] c;
        for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 8; k++) begin
                c = 3'(k);
                en <= (e == 1) ? 4'h5 : 4'hA;
                adc_mode <= 6'h15;
                reg_wr({22'h0, PISS_ADDR_PWM_SEL}, {18'h0, c[0], 1'b0, c[1], 2'b00, c, c, c});
                reg_wr({22'h0, PISS_ADDR_DAC_SEL}, {25'h0, c, 1'b0, c});
                for (int i = 0; i < 4; i++) begin
                    pat <= pats[i];
                    pair_pin <= ~pats[i][1:0];
                    fault_one_pin <= ~pats[i][2];
                    fault_two_pin <= ~pats[i][3];
                    repeat (5) @(posedge core_clk);
                    @(negedge core_clk);
                    chk("source outputs", out_vec, expect_out(c, en, pats[i]));
                    @(posedge core_clk);
                end
            end
        end
    endtask : t_codes
    task automatic t_adc();
        logic [1:0] m [3];
        logic [8:0] e;
        reg_wr({22'h0, PISS_ADDR_PWM_SEL}, 32'h0000_0092);
        for (int s = 0; s < 4; s++) begin
            e = 9'h0;
            for (int g = 0; g < 3; g++) begin
                m[g] = 2'(s + g);
                e[6 + g] = (m[g] == 2'h1) || (m[g] == 2'h2);
                e[2 * g +: 2] = (m[g] == 2'h1) ? 2'b10 : ((m[g] == 2'h2) ? 2'b01 : 2'b00);
            end
            adc_mode <= {m[2], m[1], m[0]};
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            chk("adc force", {23'h0, pwm_pair_force, pwm_force_val}, {23'h0, e});
            chk("adc source", {29'h0, pwm_pair_src}, 32'h0);
            @(posedge core_clk);
        end
    endtask : t_adc
    // ====
    // clock, timeout, main sequence
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // whole run needs about 550 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        en = 4'hF;
        {pair_pin, fault_one_pin, fault_two_pin, pat, adc_mode} = '0;
        repeat (20) @(posedge core_clk);
        chk("outputs in reset", {16'h0, out_vec}, 32'h0);
        rst <= 1'b0;
        @(posedge core_clk);
        t_map();
        t_codes();
        t_adc();
        results();
    end
endmodule : peripheral_input_source_select_tb_top
`default_nettype wire

// file: testbench/piss_periph_model.sv
// Purpose: behavioural on-chip sources feeding the select block
// Assumes: sources are same-clock levels; limits fixed at 0x800 and 0x200
// Notes: adc_mode per pair: 0 inside, 1 above high, 2 below low, 3 equal to high
`timescale 1ns/100ps
`default_nettype none
module piss_periph_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control from bench
    input wire logic [7:0] pat,
    input wire logic [5:0] adc_mode,
    // sources: cmpa, cmpb, ta0..ta3, pit, pwm sync
    output logic [7:0] src,
    output logic [11:0] hi_lim,
    output logic [11:0] lo_lim,
    output logic [35:0] adc_res
);
    // ====
    // levels
    function automatic logic [11:0] level(input logic [1:0] m);
        case (m)
            2'h1: level = 12'h900;
            2'h2: level = 12'h100;
            2'h3: level = 12'h800;
            default: level = 12'h500;
        endcase
    endfunction : level
    assign hi_lim = 12'h800;
    assign lo_lim = 12'h200;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            src <= 8'h00;
            adc_res <= 36'h0;
        end else begin
            src <= pat;
            adc_res <= {level(adc_mode[5:4]), level(adc_mode[3:2]), level(adc_mode[1:0])};
        end
    end
endmodule : piss_periph_model
`default_nettype wire
